// [core/cftf_filter_word.sv]
// Purpose: one 29-bit acceptance filter word (mask or value)
// Assumes: write strobe already decoded and qualified
// Notes: an absent word keeps zero and ignores writes
module cftf_filter_word #(
  parameter bit PRESENT = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write side
  input wire logic wr_en,
  input wire logic [cftf_pkg::ID_BITS-1:0] wdata,
  // stored word
  output logic [cftf_pkg::ID_BITS-1:0] word
);
  import cftf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ID_BITS-1:0] word;
  } cftf_word_s;

  cftf_word_s q_reg; // stored word
  cftf_word_s q_next; // next value

  // load only when built in, so an absent word reads zero
  always_comb begin
    q_next = q_reg;
    if (PRESENT && wr_en) begin
      q_next.word = wdata;
    end
  end

  // register, reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign word = q_reg.word;
endmodule

// [core/cftf_pkg.sv]
// Purpose: shared constants and carriers for the timing/fault/filter slice
// Assumes: 32-bit APB, word-per-register, byte address = 4 * index
// Notes: state codes are one-hot and match the fault state readout bits
package cftf_pkg;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CONTROL = 10'h001;
  localparam logic [9:0] IDX_INT_STATUS = 10'h010;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h014;
  localparam logic [9:0] IDX_MASK_SET = 10'h01C;
  localparam logic [9:0] IDX_UNMASK = 10'h020;
  localparam logic [9:0] IDX_NOM_TIMING = 10'h024;
  localparam logic [9:0] IDX_DATA_TIMING = 10'h028;
  localparam logic [9:0] IDX_WARN_LIMIT = 10'h02C;
  localparam logic [9:0] IDX_PASS_LIMIT = 10'h02D;
  localparam logic [9:0] IDX_FAULT_STATE = 10'h02E;
  localparam logic [9:0] IDX_RX_TALLY = 10'h030;
  localparam logic [9:0] IDX_TX_TALLY = 10'h032;
  localparam logic [9:0] IDX_NOM_ERRS = 10'h034;
  localparam logic [9:0] IDX_DATA_ERRS = 10'h036;
  localparam logic [9:0] IDX_PRESET = 10'h038;
  localparam logic [9:0] IDX_A_MASK = 10'h03C;
  localparam logic [9:0] IDX_A_VALUE = 10'h040;
  localparam logic [9:0] IDX_B_MASK = 10'h044;
  localparam logic [9:0] IDX_B_VALUE = 10'h048;
  localparam logic [9:0] IDX_C_MASK = 10'h04C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_NODE_ENABLE = 0;
  localparam int CTRL_TEST_MODE = 1;
  localparam int INT_WARNING = 2;
  localparam int INT_FAULT_CHANGE = 5;
  localparam int PRE_LOAD_TX = 9;
  localparam int PRE_LOAD_RX = 10;
  localparam int PRE_CLR_NOM = 11;
  localparam int PRE_CLR_DATA = 12;
  localparam int INT_BITS = 12;
  localparam int ID_BITS = 29;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FLT_ACTIVE = 3'b001,
    FLT_PASSIVE = 3'b010,
    FLT_BUS_OFF = 3'b100
  } cftf_fault_e;

  // nominal timing word, bit 31 down to 0
  typedef struct packed {
    logic [4:0] sync_jump_width;
    logic [7:0] rate_prescaler;
    logic [5:0] phase_segment_two;
    logic [5:0] phase_segment_one;
    logic [6:0] transit_segment;
  } cftf_nom_timing_s;

  // data-phase timing word with its reserved gaps
  typedef struct packed {
    logic [4:0] sync_jump_width;
    logic [7:0] rate_prescaler;
    logic gap18;
    logic [4:0] phase_segment_two;
    logic gap12;
    logic [4:0] phase_segment_one;
    logic gap6;
    logic [5:0] transit_segment;
  } cftf_data_timing_s;

  // error events from the protocol engine
  typedef struct packed {
    logic [3:0] rx_add;
    logic rx_dec;
    logic [3:0] tx_add;
    logic tx_dec;
    logic nominal_err;
    logic data_err;
    logic reintegrated;
  } cftf_err_ev_s;

  // state of the slice apart from the filter words
  typedef struct packed {
    logic node_enable;
    logic test_mode;
    logic [11:0] int_status;
    logic [11:0] irq_enable;
    logic [11:0] int_mask;
    cftf_nom_timing_s nom;
    cftf_data_timing_s dat;
    logic [7:0] warning_threshold;
    logic [7:0] passive_threshold;
    cftf_fault_e fault;
    logic [8:0] rx_fault_tally;
    logic [8:0] tx_fault_tally;
    logic [15:0] nominal_rate_error_tally;
    logic [15:0] data_rate_error_tally;
    logic warn_above;
    logic [1:0] hit;
    logic [31:0] rdata;
    logic slverr;
    logic irq;
  } cftf_state_s;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam cftf_nom_timing_s NOM_RST = '{5'h02, 8'h0A, 6'h05, 6'h03, 7'h05};
  localparam cftf_data_timing_s DATA_RST =
    '{5'h02, 8'h04, 1'h0, 5'h03, 1'h0, 5'h03, 1'h0, 6'h03};
  localparam logic [7:0] WARN_RST = 8'h60;
  localparam logic [7:0] PASS_RST = 8'h80;
  localparam cftf_state_s STATE_RST = '{
    node_enable: 1'b0, test_mode: 1'b0,
    int_status: 12'h000, irq_enable: 12'h000, int_mask: 12'h000,
    nom: NOM_RST, dat: DATA_RST,
    warning_threshold: WARN_RST, passive_threshold: PASS_RST,
    fault: FLT_BUS_OFF,
    rx_fault_tally: 9'h000, tx_fault_tally: 9'h000,
    nominal_rate_error_tally: 16'h0000, data_rate_error_tally: 16'h0000,
    warn_above: 1'b0, hit: 2'h0, rdata: 32'h0000_0000,
    slverr: 1'b0, irq: 1'b0};

endpackage

// [core/cftf_regs.sv]
// Purpose: timing, fault confinement and filter register slice over APB
// Assumes: zero-wait APB slave, whole-word accesses only
// Notes: read data is captured in the setup cycle, so pready stays high
module cftf_regs #(
  parameter bit FILTER_A_PRESENT = 1'b1,
  parameter bit FILTER_B_PRESENT = 1'b1,
  parameter bit FILTER_C_PRESENT = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol engine events
  input wire logic [cftf_pkg::INT_BITS-1:0] int_trigger,
  input wire cftf_pkg::cftf_err_ev_s err_ev,
  input wire logic [cftf_pkg::ID_BITS-1:0] rx_identifier,
  // settings towards the protocol engine
  output cftf_pkg::cftf_nom_timing_s nominal_timing,
  output cftf_pkg::cftf_data_timing_s data_phase_timing,
  output logic node_enable,
  output logic test_mode,
  output logic [7:0] warning_threshold,
  output logic [7:0] passive_threshold,
  // fault confinement view
  output cftf_pkg::cftf_fault_e fault_state,
  output logic [8:0] rx_fault_tally,
  output logic [8:0] tx_fault_tally,
  // filters
  output logic [1:0] filter_hit,
  output logic [cftf_pkg::ID_BITS-1:0] third_filter_mask,
  // interrupt
  output logic irq
);
  import cftf_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cftf_state_s s_reg; // all registered state except the filter words
  cftf_state_s s_next; // next state
  logic [9:0] idx; // word index of the access
  logic setup; // first cycle of a transfer
  logic wr; // write takes effect now
  logic [ID_BITS-1:0] fw_word [5]; // filter words A mask..C mask
  logic [4:0] fw_wr; // filter word write strobes
  logic [9:0] rx_sum; // rx counter before clamping
  logic [9:0] tx_sum; // tx counter before clamping
  logic [11:0] trig; // engine triggers plus the warning crossing
  logic above; // either counter at or over warning limit
  logic [31:0] rd; // read value being decoded
  logic err; // unmapped address

  assign idx = paddr[11:2];
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;

  // ----------------------------------------------------------------
  // filter words
  // ----------------------------------------------------------------
  // strobes per word
  assign fw_wr[0] = wr && (idx == IDX_A_MASK);
  assign fw_wr[1] = wr && (idx == IDX_A_VALUE);
  assign fw_wr[2] = wr && (idx == IDX_B_MASK);
  assign fw_wr[3] = wr && (idx == IDX_B_VALUE);
  assign fw_wr[4] = wr && (idx == IDX_C_MASK);

  cftf_filter_word #(.PRESENT(FILTER_A_PRESENT)) u_a_mask (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(fw_wr[0]),
    .wdata(pwdata[ID_BITS-1:0]),
    .word(fw_word[0])
  );
  cftf_filter_word #(.PRESENT(FILTER_A_PRESENT)) u_a_value (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(fw_wr[1]),
    .wdata(pwdata[ID_BITS-1:0]),
    .word(fw_word[1])
  );
  cftf_filter_word #(.PRESENT(FILTER_B_PRESENT)) u_b_mask (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(fw_wr[2]),
    .wdata(pwdata[ID_BITS-1:0]),
    .word(fw_word[2])
  );
  cftf_filter_word #(.PRESENT(FILTER_B_PRESENT)) u_b_value (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(fw_wr[3]),
    .wdata(pwdata[ID_BITS-1:0]),
    .word(fw_word[3])
  );
  cftf_filter_word #(.PRESENT(FILTER_C_PRESENT)) u_c_mask (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(fw_wr[4]),
    .wdata(pwdata[ID_BITS-1:0]),
    .word(fw_word[4])
  );

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // write-only words read zero; anything unlisted is an error
  always_comb begin
    rd = 32'h0000_0000;
    err = 1'b0;
    case (idx)
      IDX_CONTROL: begin
        rd[CTRL_NODE_ENABLE] = s_reg.node_enable;
        rd[CTRL_TEST_MODE] = s_reg.test_mode;
      end
      IDX_INT_STATUS: rd[11:0] = s_reg.int_status;
      IDX_IRQ_ENABLE: rd[11:0] = s_reg.irq_enable;
      IDX_MASK_SET: rd[11:0] = s_reg.int_mask;
      IDX_UNMASK: rd = 32'h0000_0000;
      IDX_NOM_TIMING: rd = s_reg.nom;
      IDX_DATA_TIMING: rd = s_reg.dat;
      IDX_WARN_LIMIT: rd[7:0] = s_reg.warning_threshold;
      IDX_PASS_LIMIT: rd[7:0] = s_reg.passive_threshold;
      IDX_FAULT_STATE: rd[2:0] = s_reg.fault;
      IDX_RX_TALLY: rd[8:0] = s_reg.rx_fault_tally;
      IDX_TX_TALLY: rd[8:0] = s_reg.tx_fault_tally;
      IDX_NOM_ERRS: rd[15:0] = s_reg.nominal_rate_error_tally;
      IDX_DATA_ERRS: rd[15:0] = s_reg.data_rate_error_tally;
      IDX_PRESET: rd = 32'h0000_0000;
      IDX_A_MASK: rd[ID_BITS-1:0] = fw_word[0];
      IDX_A_VALUE: rd[ID_BITS-1:0] = fw_word[1];
      IDX_B_MASK: rd[ID_BITS-1:0] = fw_word[2];
      IDX_B_VALUE: rd[ID_BITS-1:0] = fw_word[3];
      IDX_C_MASK: rd[ID_BITS-1:0] = fw_word[4];
      default: err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // counter arithmetic
  // ----------------------------------------------------------------
  // counters saturate at 511 and never wrap below zero
  always_comb begin
    rx_sum = {1'b0, s_reg.rx_fault_tally} + {6'h00, err_ev.rx_add};
    if (err_ev.rx_dec && rx_sum != 10'h000) begin
      rx_sum = rx_sum - 10'h001;
    end
    if (rx_sum > 10'h1FF) begin
      rx_sum = 10'h1FF;
    end
    tx_sum = {1'b0, s_reg.tx_fault_tally} + {6'h00, err_ev.tx_add};
    if (err_ev.tx_dec && tx_sum != 10'h000) begin
      tx_sum = tx_sum - 10'h001;
    end
    if (tx_sum > 10'h1FF) begin
      tx_sum = 10'h1FF;
    end
  end

  assign above = (s_reg.rx_fault_tally >= {1'b0, s_reg.warning_threshold}) ||
                 (s_reg.tx_fault_tally >= {1'b0, s_reg.warning_threshold});

  // internal triggers join the engine's own
  always_comb begin
    trig = int_trigger;
    trig[INT_WARNING] = int_trigger[INT_WARNING] || (above != s_reg.warn_above);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.warn_above = above;

    // control bits
    if (wr && idx == IDX_CONTROL) begin
      s_next.node_enable = pwdata[CTRL_NODE_ENABLE];
      s_next.test_mode = pwdata[CTRL_TEST_MODE];
    end

    // interrupt enable gates the output only
    if (wr && idx == IDX_IRQ_ENABLE) begin
      s_next.irq_enable = pwdata[11:0];
    end

    if (wr && idx == IDX_MASK_SET) begin
      s_next.int_mask = s_reg.int_mask | pwdata[11:0];
    end
    if (wr && idx == IDX_UNMASK) begin
      s_next.int_mask = s_reg.int_mask & ~pwdata[11:0];
    end

    if (wr && idx == IDX_NOM_TIMING && !s_reg.node_enable) begin
      s_next.nom = pwdata;
    end
    if (wr && idx == IDX_DATA_TIMING && !s_reg.node_enable) begin
      s_next.dat = pwdata;
      s_next.dat.gap18 = 1'b0;
      s_next.dat.gap12 = 1'b0;
      s_next.dat.gap6 = 1'b0;
    end

    // warning limit only in test mode
    if (wr && idx == IDX_WARN_LIMIT && s_reg.test_mode) begin
      s_next.warning_threshold = pwdata[7:0];
    end
    // passive limit only in test mode
    if (wr && idx == IDX_PASS_LIMIT && s_reg.test_mode) begin
      s_next.passive_threshold = pwdata[7:0];
    end

    // engine moves the error counters
    s_next.rx_fault_tally = rx_sum[8:0];
    s_next.tx_fault_tally = tx_sum[8:0];

    s_next.nominal_rate_error_tally = s_reg.nominal_rate_error_tally +
                                      {15'h0000, err_ev.nominal_err};
    s_next.data_rate_error_tally = s_reg.data_rate_error_tally +
                                   {15'h0000, err_ev.data_err};

    if (wr && idx == IDX_PRESET && s_reg.test_mode) begin
      if (pwdata[PRE_LOAD_TX]) begin
        s_next.tx_fault_tally = pwdata[8:0];
      end
      if (pwdata[PRE_LOAD_RX]) begin
        s_next.rx_fault_tally = pwdata[8:0];
      end
      // a same-cycle error still counts after clear
      if (pwdata[PRE_CLR_NOM]) begin
        s_next.nominal_rate_error_tally = {15'h0000, err_ev.nominal_err};
      end
      if (pwdata[PRE_CLR_DATA]) begin
        s_next.data_rate_error_tally = {15'h0000, err_ev.data_err};
      end
    end

    // reintegration from bus-off wipes both counters
    if (err_ev.reintegrated) begin
      s_next.rx_fault_tally = 9'h000;
      s_next.tx_fault_tally = 9'h000;
    end

    // fault confinement follows the new counters
    unique case (s_reg.fault)
      FLT_BUS_OFF: begin
        // bus-off only left through reintegration
        if (err_ev.reintegrated) begin
          s_next.fault = FLT_ACTIVE;
        end
      end
      FLT_ACTIVE, FLT_PASSIVE: begin
        if (s_next.tx_fault_tally[8]) begin
          s_next.fault = FLT_BUS_OFF;
        end else if (s_next.rx_fault_tally > {1'b0, s_reg.passive_threshold} ||
                     s_next.tx_fault_tally > {1'b0, s_reg.passive_threshold}) begin
          s_next.fault = FLT_PASSIVE;
        end else begin
          s_next.fault = FLT_ACTIVE;
        end
      end
      default: s_next.fault = FLT_BUS_OFF;
    endcase

    // latch unmasked triggers, set beats clear
    s_next.int_status = s_reg.int_status;
    if (wr && idx == IDX_INT_STATUS) begin
      s_next.int_status = s_reg.int_status & ~pwdata[11:0];
    end
    s_next.int_status = s_next.int_status | (trig & ~s_reg.int_mask);
    // fault change folded in here, so trig never reads s_next
    if (s_next.fault != s_reg.fault && !s_reg.int_mask[INT_FAULT_CHANGE]) begin
      s_next.int_status[INT_FAULT_CHANGE] = 1'b1;
    end
    s_next.irq = |(s_next.int_status & s_next.irq_enable);

    s_next.hit[0] = FILTER_A_PRESENT &&
                    (((rx_identifier ^ fw_word[1]) & fw_word[0]) == '0);
    s_next.hit[1] = FILTER_B_PRESENT &&
                    (((rx_identifier ^ fw_word[3]) & fw_word[2]) == '0);

    // read data and error captured in setup
    if (setup) begin
      s_next.rdata = pwrite ? 32'h0000_0000 : rd;
      s_next.slverr = err;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset lands in bus-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = s_reg.rdata;
  assign pslverr = psel && penable && s_reg.slverr;
  assign nominal_timing = s_reg.nom;
  assign data_phase_timing = s_reg.dat;
  assign node_enable = s_reg.node_enable;
  assign test_mode = s_reg.test_mode;
  assign warning_threshold = s_reg.warning_threshold;
  assign passive_threshold = s_reg.passive_threshold;
  assign fault_state = s_reg.fault;
  assign rx_fault_tally = s_reg.rx_fault_tally;
  assign tx_fault_tally = s_reg.tx_fault_tally;
  assign filter_hit = s_reg.hit;
  assign third_filter_mask = fw_word[4];
  assign irq = s_reg.irq;
endmodule

// [tb/cftf_monitor.sv]
// Purpose: port-level checks on the timing, fault and filter slice
// Assumes: zero-wait APB, byte address is four times the index
// Notes: attached to every cftf_regs instance by the bind below
module cftf_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // engine events and settings
  input wire cftf_pkg::cftf_err_ev_s err_ev,
  input wire cftf_pkg::cftf_nom_timing_s nominal_timing,
  input wire cftf_pkg::cftf_data_timing_s data_phase_timing,
  input wire logic node_enable,
  input wire logic test_mode,
  input wire logic [7:0] warning_threshold,
  input wire logic [7:0] passive_threshold,
  // fault confinement view
  input wire cftf_pkg::cftf_fault_e fault_state,
  input wire logic [8:0] rx_fault_tally,
  input wire logic [8:0] tx_fault_tally
);
  import cftf_pkg::*;
  // ----------------------------------------
  // helper decode
  // ----------------------------------------
  wire logic wr = psel && penable && pwrite; // write completes here
  wire logic [8:0] pre_val = pwdata[8:0]; // preset value field
  wire logic [7:0] lo8 = pwdata[7:0]; // byte-wide limits
  wire logic a_nom = paddr == {IDX_NOM_TIMING, 2'h0};
  wire logic a_dat = paddr == {IDX_DATA_TIMING, 2'h0};
  wire logic a_wrn = paddr == {IDX_WARN_LIMIT, 2'h0};
  wire logic a_pas = paddr == {IDX_PASS_LIMIT, 2'h0};
  wire logic a_pre = paddr == {IDX_PRESET, 2'h0};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_nom_write: assert property (wr && a_nom && !node_enable |=>
    nominal_timing == $past(pwdata)) else $error("nominal timing write lost");
  a_nom_locked: assert property (wr && a_nom && node_enable |=>
    $stable(nominal_timing)) else $error("nominal timing changed while enabled");
  a_data_locked: assert property (wr && a_dat && node_enable |=>
    $stable(data_phase_timing)) else $error("data timing changed while enabled");
  a_data_gaps: assert property ({data_phase_timing.gap18,
    data_phase_timing.gap12, data_phase_timing.gap6} == 3'h0) else $error("gap bit set");
  a_warn_gate: assert property (wr && a_wrn && !test_mode |=>
    $stable(warning_threshold)) else $error("warning limit written outside test");
  a_warn_write: assert property (wr && a_wrn && test_mode |=>
    warning_threshold == $past(lo8)) else $error("warning limit write lost");
  a_pass_gate: assert property (wr && a_pas && !test_mode |=>
    $stable(passive_threshold)) else $error("passive limit written outside test");
  a_preset_gate: assert property (wr && a_pre && !test_mode && err_ev == '0 |=>
    $stable(tx_fault_tally) && $stable(rx_fault_tally)) else $error("preset not refused");
  a_preset_tx: assert property (wr && a_pre && test_mode && pwdata[9] |=>
    tx_fault_tally == $past(pre_val)) else $error("tx preset lost");
  a_state_onehot: assert property ($onehot(fault_state))
    else $error("fault state not one-hot");
endmodule

bind cftf_regs cftf_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .err_ev, .nominal_timing, .data_phase_timing, .node_enable, .test_mode,
  .warning_threshold, .passive_threshold, .fault_state, .rx_fault_tally, .tx_fault_tally);

// [tb/tb_top.sv]
// Purpose: self-checking bench for the timing, fault and filter slice
// Assumes: zero-wait APB slave, byte address is four times the index
// Notes: table rows first, then interrupt, fault, filter and reset cases
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cftf_pkg::*;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000, int_trigger = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, irq, last_err;
  cftf_err_ev_s err_ev = '0, ev_v;
  logic [ID_BITS-1:0] rx_identifier = 29'h0, third_filter_mask;
  logic [1:0] filter_hit;
  int n_errors = 0, tests_run = 0, cyc = 0;
  // table row: write flag, byte address, write data, expected read
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x;} cftf_row_s;
  localparam cftf_row_s ROWS [33] = '{
    '{1'h0, 12'h090, 32'h0, 32'h1050A185}, '{1'h0, 12'h0A0, 32'h0, 32'h10206183},
    '{1'h0, 12'h0B0, 32'h0, 32'h60}, '{1'h0, 12'h0B4, 32'h0, 32'h80},
    '{1'h0, 12'h0B8, 32'h0, 32'h4}, '{1'h0, 12'h0C0, 32'h0, 32'h0},
    '{1'h0, 12'h0D0, 32'h0, 32'h0}, '{1'h0, 12'h0F0, 32'h0, 32'h0},
    '{1'h1, 12'h090, 32'hFFFFFFFF, 32'h0}, '{1'h0, 12'h090, 32'h0, 32'hFFFFFFFF},
    '{1'h1, 12'h0A0, 32'hFFFFFFFF, 32'h0}, '{1'h0, 12'h0A0, 32'h0, 32'hFFFBEFBF},
    '{1'h1, 12'h0B0, 32'h11, 32'h0}, '{1'h0, 12'h0B0, 32'h0, 32'h60},
    '{1'h1, 12'h0B4, 32'h7, 32'h0}, '{1'h0, 12'h0B4, 32'h0, 32'h80},
    '{1'h1, 12'h004, 32'h3, 32'h0}, '{1'h1, 12'h090, 32'h0, 32'h0},
    '{1'h0, 12'h090, 32'h0, 32'hFFFFFFFF}, '{1'h1, 12'h0A0, 32'h0, 32'h0},
    '{1'h0, 12'h0A0, 32'h0, 32'hFFFBEFBF}, '{1'h1, 12'h004, 32'h2, 32'h0},
    '{1'h1, 12'h0B0, 32'h104, 32'h0},
    '{1'h0, 12'h0B0, 32'h0, 32'h4}, '{1'h1, 12'h0B4, 32'h5, 32'h0},
    '{1'h0, 12'h0B4, 32'h0, 32'h5}, '{1'h1, 12'h0E0, 32'h610, 32'h0},
    '{1'h0, 12'h0C8, 32'h0, 32'h10}, '{1'h1, 12'h0F0, 32'hFFFFFFFF, 32'h0},
    '{1'h0, 12'h0F0, 32'h0, 32'h1FFFFFFF}, '{1'h1, 12'h100, 32'h12345678, 32'h0},
    '{1'h0, 12'h100, 32'h0, 32'h12345678}, '{1'h0, 12'h080, 32'h0, 32'h0}};

  // device under test, settings outputs watched by the bound checker
  cftf_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_trigger(int_trigger), .err_ev(err_ev),
    .rx_identifier(rx_identifier), .nominal_timing(), .data_phase_timing(),
    .node_enable(), .test_mode(), .warning_threshold(), .passive_threshold(),
    .fault_state(), .rx_fault_tally(), .tx_fault_tally(), .filter_hit(filter_hit),
    .third_filter_mask(third_filter_mask), .irq(irq));

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial forever #2.5 pclk = ~pclk;
  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      final_report;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", n, exp, got);
      n_errors++;
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk("read", q, exp);
  endtask
  // single-cycle engine pulse, then let status settle
  task pulse(input logic [11:0] t, input cftf_err_ev_s e);
    @(posedge pclk);
    int_trigger <= t;
    err_ev <= e;
    @(posedge pclk);
    int_trigger <= 12'h000;
    err_ev <= '0;
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w) chk("row", q, ROWS[i].x);
    end
    $display("table done");
    // interrupt raise, clear, mask and unmask
    // the table preset left the warning bit latched
    apb(1'h1, 12'h040, 32'hFFF);
    apb(1'h1, 12'h050, 32'h1);
    pulse(12'h001, '0);
    chk("irq", irq, 1'h1);
    rd(12'h040, 32'h1);
    apb(1'h1, 12'h040, 32'h1);
    @(posedge pclk);
    chk("irq", irq, 1'h0);
    apb(1'h1, 12'h070, 32'h1);
    pulse(12'h001, '0);
    rd(12'h040, 32'h0);
    rd(12'h070, 32'h1);
    apb(1'h1, 12'h080, 32'h1);
    rd(12'h070, 32'h0);
    pulse(12'h001, '0);
    rd(12'h040, 32'h1);
    $display("interrupts done");
    // fault confinement and error tallies
    ev_v = '0;
    ev_v.reintegrated = 1'h1;
    pulse(12'h000, ev_v);
    rd(12'h0B8, 32'h1);
    apb(1'h1, 12'h040, 32'hFFF);
    ev_v = '0;
    ev_v.rx_add = 4'h6;
    pulse(12'h000, ev_v);
    rd(12'h0B8, 32'h2);
    rd(12'h040, 32'h24);
    ev_v = '0;
    ev_v.nominal_err = 1'h1;
    ev_v.data_err = 1'h1;
    pulse(12'h000, ev_v);
    rd(12'h0D0, 32'h1);
    rd(12'h0D8, 32'h1);
    apb(1'h1, 12'h0E0, 32'h1800);
    rd(12'h0D0, 32'h0);
    rd(12'h0D8, 32'h0);
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h1, 12'h0E0, 32'h601);
    rd(12'h0C0, 32'h6);
    $display("fault done");
    // unmapped access, filters, third mask
    rd(12'h000, 32'h0);
    chk("slverr", last_err, 1'h1);
    rx_identifier <= 29'h12345678;
    repeat (3) @(posedge pclk);
    chk("hit", filter_hit, 2'h3);
    rx_identifier <= 29'h12345679;
    repeat (3) @(posedge pclk);
    chk("hit", filter_hit, 2'h2);
    apb(1'h1, 12'h130, 32'hFFFFFFFF);
    @(posedge pclk);
    chk("third", third_filter_mask, 32'h1FFFFFFF);
    // reset in mid-run restores defaults
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h0B0, 32'h60);
    rd(12'h0B8, 32'h4);
    $display("filters and reset done");
    final_report;
  end
endmodule
